// [rtl/dpw_channel.sv]
/*
 * One PWM output channel: dithered eight-plus-eight waveform and the
 * upper-byte eight-bit waveform, with phase selection.
 * Assumes counter values and the widen decision come from the same clock.
 */
`default_nettype none

module dpw_channel (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [2:0] wave_mode,
    input wire logic phase,
    input wire logic [7:0] low_cnt,
    input wire logic [7:0] high_cnt,
    input wire logic [7:0] duty_lo,
    input wire logic [7:0] dither_lo,
    input wire logic widen,
    output logic pwm_out
);

    logic [8:0] cmp_eff;
    logic raw;
    logic out_q;

    // Widened period starts high one count later
    assign cmp_eff = {1'b0, duty_lo} + {8'h00, widen};

    always_comb
    begin
        case (wave_mode)
            dpw_pkg::DPW_WAVE_DITHER:
                // High from duty match up to the overflow
                raw = ({1'b0, low_cnt} >= cmp_eff);
            dpw_pkg::DPW_WAVE_UPPER:
                raw = (high_cnt >= dither_lo);
            default:
                raw = 1'b0;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            out_q <= 1'b0;
        else if (!run)
            out_q <= 1'b0;
        else
            out_q <= phase ? ~raw : raw;
    end

    assign pwm_out = out_q;

endmodule

`default_nettype wire

// [rtl/dpw_pkg.sv]
/*
 * Package for the dithered eight-plus-eight PWM timer: register offsets,
 * field positions, reset values and mode encodings.
 * Assumes a byte-addressed register port with 32-bit words.
 */
`default_nettype none

package dpw_pkg;

    localparam int DPW_ADDR_W = 8;
    localparam int DPW_DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] DPW_OFF_CTRL = 8'h00;
    localparam logic [7:0] DPW_OFF_CLKSEL = 8'h04;
    localparam logic [7:0] DPW_OFF_PERIOD = 8'h08;
    localparam logic [7:0] DPW_OFF_DUTY = 8'h0C;
    localparam logic [7:0] DPW_OFF_STATUS = 8'h10;
    localparam logic [7:0] DPW_OFF_COUNT = 8'h14;

    // Control register fields
    localparam int DPW_CTRL_TRIG_LSB = 0;
    localparam int DPW_CTRL_MODE_LSB = 2;
    localparam int DPW_CTRL_CLEAR_BIT = 4;
    localparam int DPW_CTRL_EN_BIT = 5;
    localparam int DPW_CTRL_CH0_MODE_LSB = 16;
    localparam int DPW_CTRL_CH0_PHASE_BIT = 19;
    localparam int DPW_CTRL_CH1_MODE_LSB = 20;
    localparam int DPW_CTRL_CH1_PHASE_BIT = 23;

    // Clock select register fields
    localparam int DPW_CLK_DIV_LSB = 4;
    localparam int DPW_CLK_SRC_BIT = 7;

    // Status register fields
    localparam int DPW_STAT_OVF_BIT = 1;
    localparam int DPW_STAT_IE_BIT = 17;

    // Reset values
    localparam logic [15:0] DPW_PERIOD_RST = 16'hFFFF;
    localparam logic [15:0] DPW_DUTY_RST = 16'hFFFF;
    localparam logic [15:0] DPW_DITHER_RST = 16'hFFFF;

    // Pin sampling: fast clock, slow clock, three trigger sources
    localparam int DPW_NPINS = 5;
    localparam int DPW_PIN_HS = 0;
    localparam int DPW_PIN_LS = 1;
    localparam int DPW_PIN_CMP = 2;
    localparam int DPW_PIN_OP = 3;
    localparam int DPW_PIN_CPI = 4;

    typedef enum logic [1:0] {
        DPW_CNT_SAW = 2'b00,
        DPW_CNT_TRI = 2'b01,
        DPW_CNT_SPLIT = 2'b10,
        DPW_CNT_CHAINED = 2'b11
    } dpw_count_mode_type;

    typedef enum logic [2:0] {
        DPW_WAVE_A = 3'b000,
        DPW_WAVE_B = 3'b001,
        DPW_WAVE_C = 3'b010,
        DPW_WAVE_UPPER = 3'b011,
        DPW_WAVE_DITHER = 3'b100,
        DPW_WAVE_F = 3'b101,
        DPW_WAVE_G0 = 3'b110,
        DPW_WAVE_G1 = 3'b111
    } dpw_wave_mode_type;

    typedef enum logic [1:0] {
        DPW_TRIG_ALWAYS = 2'b00,
        DPW_TRIG_CMP = 2'b01,
        DPW_TRIG_OP = 2'b10,
        DPW_TRIG_CPI = 2'b11
    } dpw_trig_type;

endpackage

`default_nettype wire

// [rtl/dpw_timer.sv]
/*
 * Eight-plus-eight timer with two PWM channels and a plain register port.
 * Assumes timer clock sources and trigger levels arrive as asynchronous
 * pins; everything else runs on mclk.
 */
// Design decisions made here: the register offsets and the plain strobed port.
// Behaviour
// - upper-byte mode period and duty from limits
// - low byte counts, overflow bumps upper byte
// - duty compare is width N, dither picks N+1
// - dither bits carry binary fractional weights
// - dither 01h alternates N then N+1
// - single bit 2^k: last of group widened; here index 2^k of each 2^(k+1) periods is widened
// - dither bits OR together, count equals value; here the widened count per 256 periods is the bit-reversed value
// - widened positions follow overflow index pattern
// - count mode 11 selects chained counter
// - wave mode 100 selects dithered output
// - trigger 00 counts continuously
// - clock source bit and divider field
// - count only while enable bit set
// - output rises at duty compare match
// - period match falls, restarts, marks overflow
// - overflow sets flag, enable raises request
// - phase zero gives described levels
// - phase bits 19 and 23 per channel
// - clear bit zeroes count, self-clears
`default_nettype none

module dpw_timer (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic hs_clk_in,
    input wire logic ls_clk_in,
    input wire logic trig_cmp_in,
    input wire logic trig_op_in,
    input wire logic trig_cpi_in,
    output logic pwm0_out,
    output logic pwm1_out,
    output logic irq_req
);

    logic [1:0] trig_src_q;
    logic [1:0] cnt_mode_q;
    logic clear_q;
    logic enable_q;
    logic [2:0] ch0_mode_q;
    logic ch0_phase_q;
    logic [2:0] ch1_mode_q;
    logic ch1_phase_q;
    logic clk_src_q;
    logic [1:0] clk_div_q;
    logic [15:0] period_q;
    logic [15:0] duty_q;
    logic [15:0] dither_q;
    logic ovf_flag_q;
    logic irq_en_q;
    logic [31:0] rdata_q;
    logic [dpw_pkg::DPW_NPINS-1:0] pin_meta_q;
    logic [dpw_pkg::DPW_NPINS-1:0] pin_sync_q;
    logic [dpw_pkg::DPW_NPINS-1:0] pin_prev_q;
    logic [dpw_pkg::DPW_NPINS-1:0] pin_raw;
    logic [2:0] div_cnt_q;
    logic [2:0] div_max;
    logic src_rise;
    logic trig_ok;
    logic count_ok;
    logic tick;
    logic [7:0] low_q;
    logic [7:0] high_q;
    logic [7:0] ovf_idx_q;
    logic [7:0] ovf_idx_d;
    logic [7:0] idx_lsb;
    logic widen_q;
    logic ovf_evt;
    logic wr_ctrl;
    logic wr_clksel;
    logic wr_period;
    logic wr_duty;
    logic wr_status;

    assign wr_ctrl = reg_wr && (reg_addr == dpw_pkg::DPW_OFF_CTRL);
    assign wr_clksel = reg_wr && (reg_addr == dpw_pkg::DPW_OFF_CLKSEL);
    assign wr_period = reg_wr && (reg_addr == dpw_pkg::DPW_OFF_PERIOD);
    assign wr_duty = reg_wr && (reg_addr == dpw_pkg::DPW_OFF_DUTY);
    assign wr_status = reg_wr && (reg_addr == dpw_pkg::DPW_OFF_STATUS);

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            trig_src_q <= dpw_pkg::DPW_TRIG_ALWAYS;
            cnt_mode_q <= dpw_pkg::DPW_CNT_SAW;
            enable_q <= 1'b0;
            ch0_mode_q <= dpw_pkg::DPW_WAVE_A;
            ch0_phase_q <= 1'b0;
            ch1_mode_q <= dpw_pkg::DPW_WAVE_A;
            ch1_phase_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            trig_src_q <= reg_wdata[dpw_pkg::DPW_CTRL_TRIG_LSB +: 2];
            cnt_mode_q <= reg_wdata[dpw_pkg::DPW_CTRL_MODE_LSB +: 2];
            enable_q <= reg_wdata[dpw_pkg::DPW_CTRL_EN_BIT];
            ch0_mode_q <= reg_wdata[dpw_pkg::DPW_CTRL_CH0_MODE_LSB +: 3];
            ch0_phase_q <= reg_wdata[dpw_pkg::DPW_CTRL_CH0_PHASE_BIT];
            ch1_mode_q <= reg_wdata[dpw_pkg::DPW_CTRL_CH1_MODE_LSB +: 3];
            ch1_phase_q <= reg_wdata[dpw_pkg::DPW_CTRL_CH1_PHASE_BIT];
        end
    end

    // Clear request lives one cycle, the cycle in which the count is zeroed
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            clear_q <= 1'b0;
        else
            clear_q <= wr_ctrl && reg_wdata[dpw_pkg::DPW_CTRL_CLEAR_BIT];
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            clk_src_q <= 1'b0;
            clk_div_q <= 2'h0;
        end
        else if (wr_clksel)
        begin
            clk_src_q <= reg_wdata[dpw_pkg::DPW_CLK_SRC_BIT];
            clk_div_q <= reg_wdata[dpw_pkg::DPW_CLK_DIV_LSB +: 2];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            period_q <= dpw_pkg::DPW_PERIOD_RST;
        else if (wr_period)
            period_q <= reg_wdata[15:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            duty_q <= dpw_pkg::DPW_DUTY_RST;
            dither_q <= dpw_pkg::DPW_DITHER_RST;
        end
        else if (wr_duty)
        begin
            duty_q <= reg_wdata[15:0];
            dither_q <= reg_wdata[31:16];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            irq_en_q <= 1'b0;
        else if (wr_status)
            irq_en_q <= reg_wdata[dpw_pkg::DPW_STAT_IE_BIT];
    end

    // A new overflow beats a software clear in the same cycle
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            ovf_flag_q <= 1'b0;
        else if (ovf_evt)
            ovf_flag_q <= 1'b1;
        else if (wr_status && reg_wdata[dpw_pkg::DPW_STAT_OVF_BIT])
            ovf_flag_q <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            irq_req <= 1'b0;
        else
            irq_req <= ovf_flag_q && irq_en_q;
    end

    // Pin synchronisers; first stage feeds only the second
    assign pin_raw = {trig_cpi_in, trig_op_in, trig_cmp_in, ls_clk_in, hs_clk_in};

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
            pin_prev_q <= '0;
        end
        else
        begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // Source clocks must stay well below mclk/2 to be seen as edges
    always_comb
    begin
        if (clk_src_q)
            src_rise = pin_sync_q[dpw_pkg::DPW_PIN_LS] && !pin_prev_q[dpw_pkg::DPW_PIN_LS];
        else
            src_rise = pin_sync_q[dpw_pkg::DPW_PIN_HS] && !pin_prev_q[dpw_pkg::DPW_PIN_HS];
    end

    always_comb
    begin
        case (trig_src_q)
            dpw_pkg::DPW_TRIG_ALWAYS:
                trig_ok = 1'b1;
            dpw_pkg::DPW_TRIG_CMP:
                trig_ok = pin_sync_q[dpw_pkg::DPW_PIN_CMP];
            dpw_pkg::DPW_TRIG_OP:
                trig_ok = pin_sync_q[dpw_pkg::DPW_PIN_OP];
            dpw_pkg::DPW_TRIG_CPI:
                trig_ok = pin_sync_q[dpw_pkg::DPW_PIN_CPI];
            default:
                trig_ok = 1'b0;
        endcase
    end

    // Divide ratio 1, 2, 4 or 8 source edges per timer tick
    assign div_max = 3'((4'h1 << clk_div_q) - 4'h1);
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            div_cnt_q <= 3'h0;
        else if (clear_q || !enable_q)
            div_cnt_q <= 3'h0;
        else if (src_rise)
        begin
            if (div_cnt_q >= div_max)
                div_cnt_q <= 3'h0;
            else
                div_cnt_q <= div_cnt_q + 3'h1;
        end
    end

    // Only the chained count mode is built here; other modes hold the count
    assign count_ok = enable_q && trig_ok && (cnt_mode_q == dpw_pkg::DPW_CNT_CHAINED);
    assign tick = count_ok && src_rise && (div_cnt_q >= div_max);
    assign ovf_evt = tick && (low_q == period_q[7:0]);

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            low_q <= 8'h00;
        else if (clear_q)
            low_q <= 8'h00;
        else if (ovf_evt)
            low_q <= 8'h00;
        else if (tick)
            low_q <= low_q + 8'h01;
    end

    // Upper byte wraps at its own limit to set the upper-byte period
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            high_q <= 8'h00;
        else if (clear_q)
            high_q <= 8'h00;
        else if (ovf_evt)
        begin
            if (high_q == period_q[15:8])
                high_q <= 8'h00;
            else
                high_q <= high_q + 8'h01;
        end
    end

    // Overflow index names the period that is about to start
    assign ovf_idx_d = ovf_idx_q + 8'h01;
    // Lowest set bit of the index; index zero widens nothing
    assign idx_lsb = ovf_idx_d & (~ovf_idx_d + 8'h01);
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            ovf_idx_q <= 8'h00;
        else if (clear_q)
            ovf_idx_q <= 8'h00;
        else if (ovf_evt)
            ovf_idx_q <= ovf_idx_d;
    end

    // Each of the low eight dither bits owns the indices whose lowest set bit matches it
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            widen_q <= 1'b0;
        else if (clear_q)
            widen_q <= 1'b0;
        else if (ovf_evt)
            widen_q <= |(dither_q[7:0] & idx_lsb);
    end

    dpw_channel u_chan0 (
        .mclk(mclk),
        .nrst(nrst),
        .run(enable_q),
        .wave_mode(ch0_mode_q),
        .phase(ch0_phase_q),
        .low_cnt(low_q),
        .high_cnt(high_q),
        .duty_lo(duty_q[7:0]),
        .dither_lo(dither_q[7:0]),
        .widen(widen_q),
        .pwm_out(pwm0_out)
    );

    dpw_channel u_chan1 (
        .mclk(mclk),
        .nrst(nrst),
        .run(enable_q),
        .wave_mode(ch1_mode_q),
        .phase(ch1_phase_q),
        .low_cnt(low_q),
        .high_cnt(high_q),
        .duty_lo(duty_q[7:0]),
        .dither_lo(dither_q[7:0]),
        .widen(widen_q),
        .pwm_out(pwm1_out)
    );

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            rdata_q <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                dpw_pkg::DPW_OFF_CTRL:
                    rdata_q <= {8'h00, ch1_phase_q, ch1_mode_q, ch0_phase_q, ch0_mode_q,
                                10'h000, enable_q, clear_q, cnt_mode_q, trig_src_q};
                dpw_pkg::DPW_OFF_CLKSEL:
                    rdata_q <= {24'h000000, clk_src_q, 1'b0, clk_div_q, 4'h0};
                dpw_pkg::DPW_OFF_PERIOD:
                    rdata_q <= {16'h0000, period_q};
                dpw_pkg::DPW_OFF_DUTY:
                    rdata_q <= {dither_q, duty_q};
                dpw_pkg::DPW_OFF_STATUS:
                    rdata_q <= {14'h0000, irq_en_q, 15'h0000, ovf_flag_q, 1'b0};
                dpw_pkg::DPW_OFF_COUNT:
                    rdata_q <= {16'h0000, high_q, low_q};
                default:
                    rdata_q <= 32'h0000_0000;
            endcase
        end
        else
            rdata_q <= 32'h0000_0000;
    end

    assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

// [verification/dpw_chk.sv]
/*
 * Port checker for the dithered PWM timer.
 * Assumes a bind onto dpw_timer; mirrors the written control state.
 */
`default_nettype none

module dpw_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic pwm0_out,
    input wire logic pwm1_out,
    input wire logic irq_req
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [23:0] ctl_q;
    logic [15:0] per_q;
    logic ie_q;
    logic clr_q;
    logic fclr_q;
    logic wr_ctl;
    logic wr_sta;
    logic rd_cnt;
    logic pair;
    assign wr_ctl = reg_wr && reg_addr == dpw_pkg::DPW_OFF_CTRL;
    assign wr_sta = reg_wr && reg_addr == dpw_pkg::DPW_OFF_STATUS;
    assign rd_cnt = reg_rd && reg_addr == dpw_pkg::DPW_OFF_COUNT;
    assign pair = ctl_q[5] && ctl_q[18:16] == 3'h4 && ctl_q[22:20] == 3'h4
        && ctl_q[19] != ctl_q[23];
    // Write-only state that the ports cannot show
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            ctl_q <= 24'h000000;
            per_q <= dpw_pkg::DPW_PERIOD_RST;
            ie_q <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
                ctl_q <= reg_wdata[23:0];
            if (reg_wr && reg_addr == dpw_pkg::DPW_OFF_PERIOD)
                per_q <= reg_wdata[15:0];
            if (wr_sta)
                ie_q <= reg_wdata[17];
        end
    end
    always_ff @(posedge mclk)
    begin
        clr_q <= wr_ctl && reg_wdata[4];
        fclr_q <= wr_sta && reg_wdata[1];
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    property p_cnt_top;
        rd_cnt |=> reg_rdata[31:16] == 16'h0000;
    endproperty
    a_cnt_top: assert property (p_cnt_top) else $error("count upper half set");
    property p_cnt_lim;
        rd_cnt |=> reg_rdata[7:0] <= per_q[7:0] && reg_rdata[15:8] <= per_q[15:8];
    endproperty
    a_cnt_lim: assert property (p_cnt_lim) else $error("count beyond limit");
    property p_clr_self;
        reg_rd && reg_addr == dpw_pkg::DPW_OFF_CTRL && !clr_q |=> !reg_rdata[4];
    endproperty
    a_clr_self: assert property (p_clr_self) else $error("clear bit stuck");
    property p_irq_off;
        !ie_q |=> !irq_req;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("masked request");
    property p_irq_hold;
        irq_req && ie_q && !fclr_q |=> irq_req;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("request lost");
    property p_pair;
        pair && $stable(ctl_q) |-> pwm1_out != pwm0_out;
    endproperty
    a_pair: assert property (p_pair) else $error("phase pair not complementary");
    property p_en_off;
        !ctl_q[5] && $stable(ctl_q) |-> !pwm0_out && !pwm1_out;
    endproperty
    a_en_off: assert property (p_en_off) else $error("output while disabled");
    property p_mode_off;
        ctl_q[22:20] == 3'h0 && $stable(ctl_q) |-> pwm1_out == (ctl_q[5] && ctl_q[23]);
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("output in unbuilt mode");
endmodule

`default_nettype wire

// [verification/dpw_load_model.sv]
/*
 * Far side: timer clock source pins and a load timing channel zero pulses.
 * Assumes mclk at 4 ns; the pin clocks run free.
 */
`default_nettype none

module dpw_load_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic pwm_in,
    output logic hs_clk,
    output logic ls_clk,
    output logic pls_done,
    output logic [15:0] pls_len
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] cnt_q;
    // 8 and 12 mclk periods stay well under the mclk/2 limit
    initial
    begin
        hs_clk = 1'b0;
        ls_clk = 1'b0;
    end
    always #16 hs_clk = ~hs_clk;
    always #24 ls_clk = ~ls_clk;
    always_ff @(posedge mclk)
    begin
        if (!nrst || !pwm_in)
            cnt_q <= 16'h0000;
        else
            cnt_q <= cnt_q + 16'h0001;
        pls_done <= nrst && !pwm_in && cnt_q != 16'h0000;
        pls_len <= cnt_q;
    end
endmodule

`default_nettype wire

// [verification/tb_top.sv]
/*
 * Testbench for the dithered PWM timer: register tasks and width checks.
 * Assumes the load model reports channel zero high times in mclk cycles.
 */
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] CT_DITH = 32'h00C4000C;
    localparam logic [31:0] CT_UPR = 32'h0003000C;
    localparam logic [31:0] CT_HOLD = 32'h00040000;
    localparam logic [31:0] CT_BASE = 32'h0004000C;
    logic mclk;
    logic nrst;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic hs_clk;
    logic ls_clk;
    logic pwm0;
    logic pwm1;
    logic irq_req;
    logic pls_done;
    logic [15:0] pls_len;
    int failures;
    int checks;
    int cycles;
    logic [7:0] dith [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h80, 8'h03, 8'h05, 8'hFF};

    dpw_timer dut_u (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hs_clk_in(hs_clk),
        .ls_clk_in(ls_clk), .trig_cmp_in(1'b0), .trig_op_in(1'b0), .trig_cpi_in(1'b0),
        .pwm0_out(pwm0), .pwm1_out(pwm1), .irq_req(irq_req));
    dpw_load_model load_u (.mclk(mclk), .nrst(nrst), .pwm_in(pwm0), .hs_clk(hs_clk),
        .ls_clk(ls_clk), .pls_done(pls_done), .pls_len(pls_len));

    always #2 mclk = ~mclk;

    task automatic give_verdict();
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            give_verdict();
        end
    end

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        cmp(what, exp, reg_rdata);
    endtask

    // Next high time seen by the load; zero if none arrives
    task automatic pulse(output logic [31:0] v);
        v = 32'h0;
        for (int i = 0; i < 2000 && v == 32'h0; i++)
        begin
            @(negedge mclk);
            if (pls_done === 1'b1)
                v = {16'h0000, pls_len};
        end
    endtask

    // Stop, load limits, clear, then enable
    task automatic run(input logic [31:0] ct, input logic [7:0] ck, input logic [15:0] per,
        input logic [31:0] dt);
        wr(dpw_pkg::DPW_OFF_CTRL, ct);
        wr(dpw_pkg::DPW_OFF_CLKSEL, {24'h000000, ck});
        wr(dpw_pkg::DPW_OFF_PERIOD, {16'h0000, per});
        wr(dpw_pkg::DPW_OFF_DUTY, dt);
        wr(dpw_pkg::DPW_OFF_CTRL, ct | 32'h00000010);
        wr(dpw_pkg::DPW_OFF_CTRL, ct | 32'h00000020);
    endtask

    // Period k takes the dither bit at the lowest set bit of k
    function automatic int widen(input logic [7:0] d, input int k);
        widen = 0;
        for (int i = 7; i >= 0; i--)
            if (k[i])
                widen = d[i];
    endfunction

    initial
    begin
        logic [31:0] v;
        mclk = 1'b0;
        nrst = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        chk_rd(dpw_pkg::DPW_OFF_CTRL, 32'h00000000, "control");
        chk_rd(dpw_pkg::DPW_OFF_PERIOD, 32'h0000FFFF, "period");
        chk_rd(dpw_pkg::DPW_OFF_DUTY, 32'hFFFFFFFF, "duty");
        chk_rd(dpw_pkg::DPW_OFF_STATUS, 32'h00000000, "status");
        chk_rd(dpw_pkg::DPW_OFF_COUNT, 32'h00000000, "count");
        wr(8'h18, 32'hFFFFFFFF);
        chk_rd(8'h18, 32'h00000000, "unmapped");
        for (int t = 0; t < 8; t++)
        begin
            run(CT_DITH, 8'h00, 16'h0003, {8'h00, dith[t], 16'h0001});
            for (int k = 0; k < 136; k++)
            begin
                pulse(v);
                cmp("dither", (3 - widen(dith[t], k)) * 8, v);
            end
        end
        for (int k = 0; k < 5; k++)
        begin
            run(CT_BASE, k < 4 ? 8'(k << 4) : 8'h80, 16'h0003, 32'h00000001);
            pulse(v);
            cmp("tick width", k < 4 ? 24 << k : 36, v);
        end
        run(CT_UPR, 8'h00, 16'h0301, 32'h00010001);
        pulse(v);
        cmp("upper width", 32'h00000030, v);
        run(CT_HOLD, 8'h00, 16'h0003, 32'h00000001);
        repeat (50) @(posedge mclk);
        chk_rd(dpw_pkg::DPW_OFF_COUNT, 32'h00000000, "held count");
        chk_rd(dpw_pkg::DPW_OFF_CTRL, CT_HOLD | 32'h00000020, "control");
        // Dither written early in period 1 must wait for the next overflow
        run(CT_BASE, 8'h00, 16'h0003, 32'h00000001);
        pulse(v);
        wr(dpw_pkg::DPW_OFF_DUTY, 32'h00010001);
        for (int k = 1; k < 4; k++)
        begin
            pulse(v);
            cmp("held widen", k == 3 ? 16 : 24, v);
        end
        run(CT_BASE, 8'h00, 16'h0003, 32'h00000001);
        wr(dpw_pkg::DPW_OFF_STATUS, 32'h00020002);
        for (int k = 0; k < 200 && irq_req !== 1'b1; k++)
            @(negedge mclk);
        repeat (3) @(negedge mclk);
        cmp("irq", 32'h00000001, {31'h0, irq_req});
        chk_rd(dpw_pkg::DPW_OFF_STATUS, 32'h00020002, "status");
        wr(dpw_pkg::DPW_OFF_CTRL, CT_BASE);
        wr(dpw_pkg::DPW_OFF_STATUS, 32'h00020002);
        chk_rd(dpw_pkg::DPW_OFF_STATUS, 32'h00020000, "status cleared");
        cmp("irq", 32'h00000000, {31'h0, irq_req});
        wr(dpw_pkg::DPW_OFF_STATUS, 32'h00000000);
        give_verdict();
    end
endmodule

bind dpw_timer dpw_chk chk_u (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pwm0_out(pwm0_out), .pwm1_out(pwm1_out), .irq_req(irq_req));

`default_nettype wire
